// file: core/eep_pkg.sv
// shared constants and types of the ecc error profiler
package eep_pkg;
   localparam int ADDR_W = 32;
   localparam int NUM_IF = 3;
   localparam int CAM_N = 16;
   localparam int KEY_W = 4;
   localparam int FIFO_DEPTH = 4;
   localparam int FIFO_PTR_W = 2;
   localparam logic [3:0] KEY_VALID = 4'ha;
   localparam logic [3:0] KEY_RELEASE = 4'h5;
   localparam logic [3:0] KEY_RST = 4'h0;
   localparam logic [31:0] ADDR_RST = 32'h0000_0000;

   typedef logic [3:0] eep_idx_t;
   typedef logic [1:0] eep_if_t;
   typedef logic [2:0] eep_cnt_t;

   typedef struct packed {
      logic [KEY_W-1:0] key;
      logic [ADDR_W-1:0] addr;
   } eep_entry_s;

   typedef struct packed {
      logic pend;
      logic [ADDR_W-1:0] addr;
   } eep_ue_s;

   localparam eep_entry_s ENTRY_RST = '{key: KEY_RST, addr: ADDR_RST};
   localparam eep_ue_s UE_RST = '{pend: 1'b0, addr: ADDR_RST};
endpackage : eep_pkg

// file: core/eep_fifo.sv
// four-deep report queue for one reporting interface
module eep_fifo (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [eep_pkg::ADDR_W-1:0] in_addr,
   output logic out_valid,
   input wire logic out_ready,
   output logic [eep_pkg::ADDR_W-1:0] out_addr,
   output logic full
);
   logic [eep_pkg::ADDR_W-1:0] mem [eep_pkg::FIFO_DEPTH];
   logic [eep_pkg::ADDR_W-1:0] next_mem [eep_pkg::FIFO_DEPTH];
   logic [eep_pkg::FIFO_PTR_W-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
   eep_pkg::eep_cnt_t count, next_count;
   logic push, pop;

   assign full = (count == eep_pkg::eep_cnt_t'(eep_pkg::FIFO_DEPTH));
   assign in_ready = !full;
   assign out_valid = (count != 3'h0);
   assign out_addr = mem[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      next_mem = mem;
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count = count;
      if (push) begin
         next_mem[wr_ptr] = in_addr;
         next_wr_ptr = wr_ptr + 2'h1;
      end
      if (pop) begin
         next_rd_ptr = rd_ptr + 2'h1;
      end
      if (push && !pop) begin
         next_count = count + 3'h1;
      end else if (pop && !push) begin
         next_count = count - 3'h1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         for (int i = 0; i < eep_pkg::FIFO_DEPTH; i++) begin
            mem[i] <= eep_pkg::ADDR_RST;
         end
         wr_ptr <= 2'h0;
         rd_ptr <= 2'h0;
         count <= 3'h0;
      end else begin
         mem <= next_mem;
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
   end
endmodule : eep_fifo

// file: core/eep_top.sv
// ecc error profiler: fault address filter with cam, queues and collector signalling
module eep_top (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [eep_pkg::NUM_IF-1:0] ce_valid,
   input wire logic [eep_pkg::NUM_IF-1:0][eep_pkg::ADDR_W-1:0] ce_addr,
   output logic [eep_pkg::NUM_IF-1:0] ce_ready,
   input wire logic ue_valid,
   input wire logic [eep_pkg::ADDR_W-1:0] ue_addr,
   input wire logic ue_clr,
   input wire logic cfg_report_en,
   input wire logic diag_wr,
   input wire eep_pkg::eep_idx_t diag_idx,
   input wire eep_pkg::eep_entry_s diag_wdata,
   output eep_pkg::eep_entry_s diag_rdata,
   output eep_pkg::eep_ue_s ue_status,
   output logic err_grp1,
   output logic err_grp2,
   output logic irq_full
);
   logic [eep_pkg::NUM_IF-1:0] head_valid, pop_vec, fifo_full;
   logic [eep_pkg::NUM_IF-1:0][eep_pkg::ADDR_W-1:0] head_addr;

   // per-interface queues
   for (genvar g = 0; g < eep_pkg::NUM_IF; g++) begin : g_q
      eep_fifo u_fifo (
         .clk_sys(clk_sys),
         .rst(rst),
         .in_valid(ce_valid[g]),
         .in_ready(ce_ready[g]),
         .in_addr(ce_addr[g]),
         .out_valid(head_valid[g]),
         .out_ready(pop_vec[g]),
         .out_addr(head_addr[g]),
         .full(fifo_full[g])
      );
   end

   // round-robin pick of one queue head per cycle
   eep_pkg::eep_if_t rr_last, next_rr_last, pick_idx;
   logic pick;
   logic s_valid, next_s_valid;
   logic [eep_pkg::ADDR_W-1:0] s_addr, next_s_addr;

   always_comb begin
      int cand;
      cand = 0;
      pick = 1'b0;
      pick_idx = rr_last;
      for (int k = eep_pkg::NUM_IF; k >= 1; k--) begin
         cand = (int'(rr_last) + k) % eep_pkg::NUM_IF;
         if (head_valid[cand]) begin
            pick = 1'b1;
            pick_idx = eep_pkg::eep_if_t'(cand);
         end
      end
      for (int i = 0; i < eep_pkg::NUM_IF; i++) begin
         pop_vec[i] = pick && (pick_idx == eep_pkg::eep_if_t'(i));
      end
      next_rr_last = pick ? pick_idx : rr_last;
      next_s_valid = pick;
      next_s_addr = head_addr[pick_idx];
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rr_last <= 2'h0;
         s_valid <= 1'b0;
         s_addr <= eep_pkg::ADDR_RST;
      end else begin
         rr_last <= next_rr_last;
         s_valid <= next_s_valid;
         s_addr <= next_s_addr;
      end
   end

   // address table
   eep_pkg::eep_entry_s cam [eep_pkg::CAM_N];
   eep_pkg::eep_entry_s next_cam [eep_pkg::CAM_N];
   eep_pkg::eep_entry_s next_diag_rdata;
   logic [eep_pkg::CAM_N-1:0] occ, hit_vec;
   logic hit, cam_full, store;
   eep_pkg::eep_idx_t free_idx;

   always_comb begin
      free_idx = 4'h0;
      for (int i = eep_pkg::CAM_N - 1; i >= 0; i--) begin
         occ[i] = (cam[i].key == eep_pkg::KEY_VALID);
         hit_vec[i] = occ[i] && (cam[i].addr == s_addr);
         if (!occ[i]) begin
            free_idx = eep_pkg::eep_idx_t'(i);
         end
      end
   end

   assign hit = |hit_vec;
   assign cam_full = &occ;
   assign store = s_valid && !hit && !cam_full;

   always_comb begin
      next_cam = cam;
      // a release key or any diagnostic value lands as written
      if (diag_wr) begin
         next_cam[diag_idx] = diag_wdata;
      end
      // hardware store wins over a diagnostic write to the same entry
      if (store) begin
         next_cam[free_idx].key = eep_pkg::KEY_VALID;
         next_cam[free_idx].addr = s_addr;
      end
      next_diag_rdata = cam[diag_idx];
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         for (int i = 0; i < eep_pkg::CAM_N; i++) begin
            cam[i] <= eep_pkg::ENTRY_RST;
         end
         diag_rdata <= eep_pkg::ENTRY_RST;
      end else begin
         cam <= next_cam;
         diag_rdata <= next_diag_rdata;
      end
   end

   // collector signals, uncorrectable status and interrupt
   logic next_err_grp1, next_err_grp2, next_irq_full;
   eep_pkg::eep_ue_s next_ue_status;

   always_comb begin
      // a hit falls through with nothing raised
      next_err_grp1 = s_valid && !hit && (cam_full || cfg_report_en);
      next_err_grp2 = ue_valid;
      next_ue_status = ue_status;
      if (ue_clr) begin
         next_ue_status.pend = 1'b0;
      end
      // a new fault beats a clear in the same cycle
      if (ue_valid) begin
         next_ue_status.pend = 1'b1;
         next_ue_status.addr = ue_addr;
      end
      next_irq_full = (|fifo_full) || cam_full;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         err_grp1 <= 1'b0;
         err_grp2 <= 1'b0;
         ue_status <= eep_pkg::UE_RST;
         irq_full <= 1'b0;
      end else begin
         err_grp1 <= next_err_grp1;
         err_grp2 <= next_err_grp2;
         ue_status <= next_ue_status;
         irq_full <= next_irq_full;
      end
   end

   // checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   hit_silent_a: assert property (s_valid && hit |=> !err_grp1)
      else $error("group 1 raised on a table hit");

   full_miss_signal_a: assert property (s_valid && !hit && cam_full |=> err_grp1)
      else $error("full-table miss did not raise group 1");

   store_gated_a: assert property (s_valid && !hit && !cam_full |=> err_grp1 == $past(cfg_report_en))
      else $error("stored miss signal does not follow the enable");

   store_key_a: assert property (store |=> cam[$past(free_idx)].key == eep_pkg::KEY_VALID
         && cam[$past(free_idx)].addr == $past(s_addr))
      else $error("stored entry lacks key 1010 or address");

   full_drop_a: assert property (s_valid && !hit && cam_full && !diag_wr |=> occ == $past(occ))
      else $error("miss on a full table changed the table");

   release_a: assert property (diag_wr && diag_wdata.key == eep_pkg::KEY_RELEASE
         && !(store && free_idx == diag_idx) |=> !occ[$past(diag_idx)])
      else $error("released entry still occupied");

   pick_search_a: assert property ((|head_valid) |=> s_valid && s_addr == $past(head_addr[pick_idx]))
      else $error("pending report not searched in the next cycle");

   ue_capture_a: assert property (ue_valid |=> err_grp2 && ue_status.pend
         && ue_status.addr == $past(ue_addr))
      else $error("uncorrectable address not captured");

   grp2_pulse_a: assert property (!ue_valid |=> !err_grp2)
      else $error("group 2 raised without an uncorrectable fault");

   one_pop_a: assert property ($onehot0(pop_vec))
      else $error("more than one queue popped in a cycle");

   irq_full_a: assert property ((cam_full || (|fifo_full)) |=> irq_full)
      else $error("full condition did not raise the interrupt");

   hit_c: cover property (s_valid && hit);
   store_c: cover property (store ##1 err_grp1);
   full_miss_c: cover property (s_valid && !hit && cam_full);
   all_busy_c: cover property (&head_valid);
endmodule : eep_top

// file: dv/eep_reporter.sv
// model of the reporting units: one queue of fault addresses per lane
module eep_reporter (
   input wire logic clk_sys,
   input wire logic [eep_pkg::NUM_IF-1:0] ce_ready,
   output logic [eep_pkg::NUM_IF-1:0] ce_valid,
   output logic [eep_pkg::NUM_IF-1:0][eep_pkg::ADDR_W-1:0] ce_addr
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] q[eep_pkg::NUM_IF][$];
   logic [eep_pkg::NUM_IF-1:0] taken = 3'h0;
   initial begin
      ce_valid = 3'h0;
      ce_addr = '0;
   end
   task send(input int lane, input logic [31:0] a);
      q[lane].push_back(a);
   endtask : send
   // a report is held until it is taken, then the next follows or the lane is released
   always @(posedge clk_sys) taken <= ce_valid & ce_ready;
   always @(negedge clk_sys) begin
      for (int i = 0; i < eep_pkg::NUM_IF; i++) begin
         if (!ce_valid[i] || taken[i]) begin
            ce_valid[i] = (q[i].size() != 0);
            // released address lines toggle so that no stale value looks valid
            ce_addr[i] = ce_valid[i] ? q[i].pop_front() : ~ce_addr[i];
         end
      end
   end
endmodule : eep_reporter

// file: dv/test_eep_top.sv
// self-checking bench of the ecc error profiler
module test_eep_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [2:0] ce_valid, ce_ready;
   logic [2:0][31:0] ce_addr;
   logic ue_valid = 1'b0, ue_clr = 1'b0, cfg_report_en = 1'b0, diag_wr = 1'b0;
   logic [31:0] ue_addr = 32'h0, lfsr = 32'h0001_39d3;
   eep_pkg::eep_idx_t diag_idx = 4'h0;
   eep_pkg::eep_entry_s diag_wdata = eep_pkg::ENTRY_RST, diag_rdata, cam[16];
   eep_pkg::eep_ue_s ue_status;
   logic err_grp1, err_grp2, irq_full, saw_stall = 1'b0;
   int error_cnt = 0, checks = 0, g1_cnt = 0, g1_exp = 0, cyc = 0;
   always #2 clk_sys = ~clk_sys;
   eep_top u_dut (.clk_sys(clk_sys), .rst(rst), .ce_valid(ce_valid), .ce_addr(ce_addr), .ce_ready(ce_ready),
      .ue_valid(ue_valid), .ue_addr(ue_addr), .ue_clr(ue_clr), .cfg_report_en(cfg_report_en),
      .diag_wr(diag_wr), .diag_idx(diag_idx), .diag_wdata(diag_wdata), .diag_rdata(diag_rdata),
      .ue_status(ue_status), .err_grp1(err_grp1), .err_grp2(err_grp2), .irq_full(irq_full));
   eep_reporter u_rep (.clk_sys(clk_sys), .ce_ready(ce_ready), .ce_valid(ce_valid), .ce_addr(ce_addr));
   always @(posedge clk_sys) begin
      g1_cnt <= g1_cnt + int'(err_grp1 === 1'b1);
      if ((ce_valid & ~ce_ready) != 3'h0) saw_stall <= 1'b1;
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt++;
         results();
      end
   end
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c1_1db7 : 32'h0);
   endfunction : nxt
   task chk(input logic [35:0] seen, input logic [35:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task results;
      $display("errors=%0d checks=%0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : results
   // reference table: hit drops, miss stores at lowest free index, full miss only signals
   task model(input logic [31:0] a);
      int f;
      f = -1;
      for (int i = 15; i >= 0; i--) begin
         if (cam[i].key == 4'ha && cam[i].addr == a) return;
         if (cam[i].key != 4'ha) f = i;
      end
      if (f < 0) g1_exp++;
      else begin
         cam[f] = '{key: 4'ha, addr: a};
         g1_exp += int'(cfg_report_en);
      end
   endtask : model
   task rep(input int lane, input logic [31:0] a);
      u_rep.send(lane, a);
      model(a);
   endtask : rep
   task drain;
      int n;
      n = 0;
      repeat (2) @(negedge clk_sys);
      while (ce_valid != 3'h0 && n < 200) begin
         @(negedge clk_sys);
         n++;
      end
      // queued reports of all lanes may still wait for their search after the lanes release
      repeat (20) @(negedge clk_sys);
      chk(36'(g1_cnt), 36'(g1_exp));
   endtask : drain
   task rd(input int i);
      diag_idx = i[3:0];
      @(negedge clk_sys);
      chk(diag_rdata, cam[i]);
   endtask : rd
   task wr(input int i, input logic [3:0] k, input logic [31:0] a);
      diag_idx = i[3:0];
      diag_wdata = '{key: k, addr: a};
      diag_wr = 1'b1;
      @(negedge clk_sys);
      diag_wr = 1'b0;
      cam[i] = diag_wdata;
      @(negedge clk_sys);
   endtask : wr
   initial begin
      for (int i = 0; i < 16; i++) cam[i] = eep_pkg::ENTRY_RST;
      repeat (8) @(negedge clk_sys);
      rst = 1'b0;
      chk({33'h0, ce_ready}, 36'h7);
      chk({33'h0, err_grp1, err_grp2, irq_full}, 36'h0);
      rd(0);
      for (int n = 0; n < 48; n++) begin
         lfsr = nxt(lfsr);
         cfg_report_en = lfsr[8];
         rep(lfsr[1:0] % 3, {27'h0, lfsr[6:2]} | 32'h1000_0000);
         drain();
      end
      for (int n = 0; n < 17; n++) begin
         rep(n % 3, 32'h2000_0000 + n);
         drain();
      end
      chk({35'h0, irq_full}, 36'h1);
      for (int i = 0; i < 16; i++) rd(i);
      wr(3, 4'h5, 32'h0);
      wr(4, 4'h3, 32'hdead_beef);
      wr(9, 4'ha, 32'h3000_0009);
      repeat (3) @(negedge clk_sys);
      chk({35'h0, irq_full}, 36'h0);
      cfg_report_en = 1'b1;
      // lane 1 was served last, so round robin searches lane 2, then lane 0, then lane 1
      rep(2, 32'h3000_0002);
      rep(0, 32'h3000_0009);
      rep(1, 32'h3000_0001);
      drain();
      rd(3);
      rd(4);
      rd(9);
      for (int k = 0; k < 6; k++) begin
         for (int l = 0; l < 3; l++) rep(l, 32'h4000_0000 + k * 3 + l);
      end
      drain();
      chk({35'h0, saw_stall}, 36'h1);
      ue_addr = 32'h5a5a_0123;
      ue_valid = 1'b1;
      @(negedge clk_sys);
      ue_valid = 1'b0;
      chk({35'h0, err_grp2}, 36'h1);
      chk(ue_status, {3'h0, 1'b1, ue_addr});
      ue_clr = 1'b1;
      @(negedge clk_sys);
      ue_clr = 1'b0;
      @(negedge clk_sys);
      chk({34'h0, err_grp2, ue_status.pend}, 36'h0);
      results();
   end
endmodule : test_eep_top
